//--- design/prog_port_map.svh
`ifndef PROG_PORT_MAP_SVH
`define PROG_PORT_MAP_SVH
`define ACT_ADDR        2'h0
`define ACT_DATA        2'h1
`define ACT_CMD         2'h2
`define CMD_ERASE       8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_PROG     8'h10
`define CMD_WR_DATA     8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_LOCKFUSE 8'h04
`define CMD_RD_PROG     8'h02
`define CMD_RD_DATA     8'h03
`define BIT_SDL_FUSE    5
`define BIT_FAST_FUSE   0
`define BIT_LOCK_TWO    2
`define BIT_LOCK_ONE    1
`define RD_BIT_LOCK_ONE 7
`define RD_BIT_LOCK_TWO 6
`define PROG_WORDS      13'h1000
`define DATA_BYTES      13'h0200
`define SIG_COUNT       8'h03
`define ERASED_BYTE     8'hff
`define SDL_FUSE_RST    1'h0
`define FAST_FUSE_RST   1'h1
`define CLK_PERIOD_NS   50
`define WRITE_TIME_NS   700000
`endif

//--- design/prog_port_pkg.sv
package prog_port_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_HOLD} phase_t;
   typedef struct packed {
      phase_t      phase;
      logic [7:0]  cmd;
      logic [7:0]  addr_hi;
      logic [7:0]  addr_lo;
      logic [7:0]  data_lo;
      logic [7:0]  data_hi;
      logic        lock_one;
      logic        lock_two;
      logic        sdl_fuse;
      logic        fast_fuse;
      logic        wr_high;
      logic [15:0] cnt;
      logic [12:0] erase_idx;
      logic        ld_prev;
      logic        wr_prev;
      logic [7:0]  dout;
      logic        doe;
      logic        rdy;
   } port_state_t;
endpackage : prog_port_pkg

//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,  // System clock
   input  wire logic         rst,  // Synchronous reset
   input  wire logic         ce,   // Clock enable
   input  wire logic [W-1:0] d,    // Asynchronous pins
   output logic      [W-1:0] q     // Synchronised pins
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_t;

   sync_t s_r;
   sync_t s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.meta = d;
      s_nxt.q    = s_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= {INIT, INIT};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.q;
endmodule : pin_sync
`default_nettype wire

//--- design/parallel_program_port.sv
// Function
// - Action code 10 with load pulse latches data bus as command
// - Action code 00 with load pulse latches an address byte
// - Byte select high loads high address byte, low loads low byte
// - Action code 01 latches data bus as low or high data byte
// - Command 80 erases, 10 writes program memory, 11 writes data memory
// - Command 40 writes fuses, 20 writes lock bits
// - Command 02 reads program memory, 03 reads data memory at address
// - Ready/busy low while programming, high when ready
// - Data bus driven only while output enable is low
// - Write strobe starts programming; busy until done, programmer waits
// - Byte select at strobe picks low or high program byte
// - Command and address kept across operations
// - Program read gives low byte for select 0, high for 1
// - Data read with select low gives addressed byte
// - Erase clears arrays then locks; fuses untouched
// - Erase runs during wide strobe; ready/busy stays high
// - Fuse write: bit 5 serial fuse, bit 0 fast start; no busy
// - Lock write: bit 2 lock two, bit 1 lock one; 0 programs
// - Lock bits return unprogrammed only by chip erase or by reset
// - Lock/fuse read with select high: bits 7,6,5,0
// - Signature read gives identity byte chosen by low address 00-02
`timescale 1ns/1ps
`default_nettype none
`include "prog_port_map.svh"
module parallel_program_port #(
   parameter int unsigned WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS,
   parameter logic [7:0]  SIG_BYTE0    = 8'h5a, // Arbitrary identity value
   parameter logic [7:0]  SIG_BYTE1    = 8'ha5, // Arbitrary identity value
   parameter logic [7:0]  SIG_BYTE2    = 8'h3c  // Arbitrary identity value
) (
   input  wire logic       clk,              // 20 MHz clock
   input  wire logic       rst,              // Synchronous reset
   input  wire logic       ce,               // Clock enable
   input  wire logic       prog_mode_pin,    // High voltage seen on reset pin
   input  wire logic       load_pulse_pin,   // Load clock, rising edge acts
   input  wire logic       action_code_bit0, // Action code bit 0
   input  wire logic       action_code_bit1, // Action code bit 1
   input  wire logic       byte_select_pin,  // Low/high byte select
   input  wire logic       write_n_pin,      // Program strobe, active low
   input  wire logic       out_enable_n_pin, // Output enable, active low
   input  wire logic [7:0] data_in,          // Data bus input side
   output logic      [7:0] data_out,         // Data bus output side
   output logic            data_oe,          // Data bus output enable
   output logic            ready_busy_out    // 1 ready, 0 busy
);
   localparam logic [15:0] WR_LOAD = 16'(WRITE_CYCLES - 1);

   prog_port_pkg::port_state_t s_r;
   prog_port_pkg::port_state_t s_nxt;

   logic [7:0]  prog_lo [`PROG_WORDS];
   logic [7:0]  prog_hi [`PROG_WORDS];
   logic [7:0]  data_mem [`DATA_BYTES];

   logic [14:0] pins_s;
   logic [7:0]  din_s;
   logic [1:0]  act_s;
   logic        en_s, ld_s, bs_s, wr_n_s, oe_n_s;
   logic        ld_rise, wr_fall, wr_block, rd_block;
   logic        erase_we, prog_we, data_we;
   logic [11:0] pa;
   logic [8:0]  da;
   logic [7:0]  rd_byte;

   pin_sync #(
      .W    (15),
      .INIT (15'h1800)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({prog_mode_pin, load_pulse_pin, write_n_pin, out_enable_n_pin,
             byte_select_pin, action_code_bit1, action_code_bit0, data_in}),
      .q   (pins_s)
   );

   assign {en_s, ld_s, wr_n_s, oe_n_s, bs_s, act_s, din_s} = pins_s[14:0];
   assign ld_rise = ld_s & ~s_r.ld_prev;
   assign wr_fall = ~wr_n_s & s_r.wr_prev;
   assign pa      = {s_r.addr_hi[3:0], s_r.addr_lo};
   assign da      = {s_r.addr_hi[0], s_r.addr_lo};
   // Lock one programmed stops writes; both programmed stop verify too
   assign wr_block = ~s_r.lock_one;
   assign rd_block = ~s_r.lock_one & ~s_r.lock_two;
   assign erase_we = (s_r.phase == prog_port_pkg::ST_ERASE) & ~wr_n_s
                     & (s_r.erase_idx < `PROG_WORDS);
   assign prog_we  = (s_r.phase == prog_port_pkg::ST_PROG) & (s_r.cnt == 16'h0000)
                     & (s_r.cmd == `CMD_WR_PROG);
   assign data_we  = (s_r.phase == prog_port_pkg::ST_PROG) & (s_r.cnt == 16'h0000)
                     & (s_r.cmd == `CMD_WR_DATA);

   always_comb begin
      rd_byte = `ERASED_BYTE;
      case (s_r.cmd)
         `CMD_RD_PROG: begin
            if (!rd_block) begin
               rd_byte = bs_s ? prog_hi[pa] : prog_lo[pa];
            end
         end
         `CMD_RD_DATA: begin
            if (!rd_block && !bs_s) begin
               rd_byte = data_mem[da];
            end
         end
         `CMD_RD_LOCKFUSE: begin
            if (bs_s) begin
               rd_byte                   = 8'hff;
               rd_byte[`RD_BIT_LOCK_ONE] = s_r.lock_one;
               rd_byte[`RD_BIT_LOCK_TWO] = s_r.lock_two;
               rd_byte[`BIT_SDL_FUSE]    = s_r.sdl_fuse;
               rd_byte[`BIT_FAST_FUSE]   = s_r.fast_fuse;
            end
         end
         `CMD_RD_SIG: begin
            if (!bs_s) begin
               case (s_r.addr_lo)
                  8'h00:   rd_byte = SIG_BYTE0;
                  8'h01:   rd_byte = SIG_BYTE1;
                  8'h02:   rd_byte = SIG_BYTE2;
                  default: rd_byte = `ERASED_BYTE;
               endcase
            end
         end
         default: rd_byte = `ERASED_BYTE;
      endcase
   end

   always_comb begin
      s_nxt         = s_r;
      s_nxt.ld_prev = ld_s;
      s_nxt.wr_prev = wr_n_s;
      s_nxt.doe     = en_s & ~oe_n_s;
      s_nxt.dout    = rd_byte;
      // Loads are kept until replaced, so several accesses share them
      if (en_s && ld_rise) begin
         case (act_s)
            `ACT_CMD: s_nxt.cmd = din_s;
            `ACT_ADDR: begin
               if (bs_s) begin
                  s_nxt.addr_hi = din_s;
               end else begin
                  s_nxt.addr_lo = din_s;
               end
            end
            `ACT_DATA: begin
               if (bs_s) begin
                  s_nxt.data_hi = din_s;
               end else begin
                  s_nxt.data_lo = din_s;
               end
            end
            default: ;
         endcase
      end
      case (s_r.phase)
         prog_port_pkg::ST_IDLE: begin
            if (en_s && wr_fall) begin
               case (s_r.cmd)
                  `CMD_ERASE: begin
                     s_nxt.phase     = prog_port_pkg::ST_ERASE;
                     s_nxt.erase_idx = 13'h0000;
                  end
                  `CMD_WR_FUSE: begin
                     s_nxt.phase = prog_port_pkg::ST_HOLD;
                     if (!wr_block) begin
                        s_nxt.sdl_fuse  = s_r.data_lo[`BIT_SDL_FUSE];
                        s_nxt.fast_fuse = s_r.data_lo[`BIT_FAST_FUSE];
                     end
                  end
                  `CMD_WR_LOCK: begin
                     // Only programming is possible here
                     s_nxt.lock_one = s_r.lock_one & s_r.data_lo[`BIT_LOCK_ONE];
                     s_nxt.lock_two = s_r.lock_two & s_r.data_lo[`BIT_LOCK_TWO];
                     s_nxt.phase    = prog_port_pkg::ST_PROG;
                     s_nxt.cnt      = WR_LOAD;
                     s_nxt.rdy      = 1'b0;
                  end
                  `CMD_WR_PROG, `CMD_WR_DATA: begin
                     if (!wr_block) begin
                        s_nxt.phase   = prog_port_pkg::ST_PROG;
                        s_nxt.cnt     = WR_LOAD;
                        s_nxt.rdy     = 1'b0;
                        s_nxt.wr_high = bs_s;
                     end
                  end
                  default: ;
               endcase
            end
         end
         prog_port_pkg::ST_PROG: begin
            if (s_r.cnt == 16'h0000) begin
               s_nxt.phase = prog_port_pkg::ST_IDLE;
               s_nxt.rdy   = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end
         end
         prog_port_pkg::ST_ERASE: begin
            // Whole sweep takes 4096 cycles, far below the least pulse
            if (wr_n_s) begin
               s_nxt.phase = prog_port_pkg::ST_IDLE;
            end else if (s_r.erase_idx == `PROG_WORDS) begin
               s_nxt.lock_one = 1'b1;
               s_nxt.lock_two = 1'b1;
               s_nxt.phase    = prog_port_pkg::ST_HOLD;
            end else begin
               s_nxt.erase_idx = s_r.erase_idx + 13'h0001;
            end
         end
         prog_port_pkg::ST_HOLD: begin
            if (wr_n_s) begin
               s_nxt.phase = prog_port_pkg::ST_IDLE;
            end
         end
         default: s_nxt.phase = prog_port_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r           <= '0;
         s_r.rdy       <= 1'b1;
         s_r.wr_prev   <= 1'b1;
         s_r.lock_one  <= 1'b1;
         s_r.lock_two  <= 1'b1;
         s_r.sdl_fuse  <= `SDL_FUSE_RST;
         s_r.fast_fuse <= `FAST_FUSE_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         if (erase_we) begin
            prog_lo[s_r.erase_idx[11:0]] <= `ERASED_BYTE;
            prog_hi[s_r.erase_idx[11:0]] <= `ERASED_BYTE;
            if (s_r.erase_idx < `DATA_BYTES) begin
               data_mem[s_r.erase_idx[8:0]] <= `ERASED_BYTE;
            end
         end
         if (prog_we && s_r.wr_high) begin
            prog_hi[pa] <= s_r.data_hi;
         end
         if (prog_we && !s_r.wr_high) begin
            prog_lo[pa] <= s_r.data_lo;
         end
         if (data_we) begin
            data_mem[da] <= s_r.data_lo;
         end
      end
   end

   assign data_out       = s_r.dout;
   assign data_oe        = s_r.doe;
   assign ready_busy_out = s_r.rdy;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   cmd_load_a: assert property (ce && en_s && ld_rise && act_s == `ACT_CMD
      |=> s_r.cmd == $past(din_s))
      else $error("command not latched");
   addr_hi_a: assert property (ce && en_s && ld_rise && act_s == `ACT_ADDR && bs_s
      |=> s_r.addr_hi == $past(din_s) && $stable(s_r.addr_lo))
      else $error("high address byte not latched");
   addr_lo_a: assert property (ce && en_s && ld_rise && act_s == `ACT_ADDR && !bs_s
      |=> s_r.addr_lo == $past(din_s) && $stable(s_r.addr_hi))
      else $error("low address byte not latched");
   data_load_a: assert property (ce && en_s && ld_rise && act_s == `ACT_DATA
      |=> ($past(bs_s) ? s_r.data_hi : s_r.data_lo) == $past(din_s))
      else $error("data byte not latched");
   idle_code_a: assert property (ce && ld_rise && act_s == 2'h3
      |=> $stable(s_r.cmd) && $stable(s_r.addr_hi) && $stable(s_r.addr_lo)
          && $stable(s_r.data_lo) && $stable(s_r.data_hi))
      else $error("idle action changed a register");
   busy_start_a: assert property (ce && en_s && wr_fall && !wr_block
      && s_r.phase == prog_port_pkg::ST_IDLE && s_r.cmd == `CMD_WR_PROG
      |=> !ready_busy_out ##1 !ready_busy_out)
      else $error("busy not raised by write strobe");
   busy_low_a: assert property (s_r.phase == prog_port_pkg::ST_PROG |-> !ready_busy_out)
      else $error("ready while programming");
   erase_rdy_a: assert property (s_r.phase == prog_port_pkg::ST_ERASE
      |-> ready_busy_out)
      else $error("ready/busy moved during erase");
   bus_drive_a: assert property (data_oe |-> !$past(oe_n_s))
      else $error("bus driven without output enable");
   lock_sticky_a: assert property (!s_r.lock_one && s_r.phase != prog_port_pkg::ST_ERASE
      |=> !s_r.lock_one)
      else $error("lock released outside erase");
   fuse_keep_a: assert property (s_r.phase == prog_port_pkg::ST_ERASE
      |=> $stable(s_r.sdl_fuse) && $stable(s_r.fast_fuse))
      else $error("erase touched fuses");

   erase_done_c: cover property (s_r.phase == prog_port_pkg::ST_ERASE
      ##1 s_r.phase == prog_port_pkg::ST_HOLD);
   write_done_c: cover property (prog_we);
   read_high_c: cover property (data_oe && s_r.cmd == `CMD_RD_PROG && bs_s);
   sig_read_c: cover property (data_oe && s_r.cmd == `CMD_RD_SIG);
endmodule : parallel_program_port
`default_nettype wire

//--- verification/prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_model (
   input  wire logic       clk,              // System clock
   input  wire logic [7:0] data_out,         // Device drive value
   input  wire logic       data_oe,          // Device drives bus
   input  wire logic       ready_busy_out,   // 1 ready, 0 busy
   output logic            prog_mode_pin,    // Programming voltage
   output logic            load_pulse_pin,   // Load clock
   output logic            action_code_bit0, // Action code bit 0
   output logic            action_code_bit1, // Action code bit 1
   output logic            byte_select_pin,  // Byte select
   output logic            write_n_pin,      // Program strobe
   output logic            out_enable_n_pin, // Output enable
   output logic      [7:0] data_in           // Resolved bus level
);
   logic [7:0] drv_r;

   // Released bus shows the inverted last value
   assign data_in = data_oe ? data_out : drv_r;

   initial begin
      prog_mode_pin    = 1'b0;
      load_pulse_pin   = 1'b0;
      action_code_bit0 = 1'b1;
      action_code_bit1 = 1'b1;
      byte_select_pin  = 1'b0;
      write_n_pin      = 1'b1;
      out_enable_n_pin = 1'b1;
      drv_r            = 8'h00;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   task automatic enter();
      @(posedge clk);
      byte_select_pin <= 1'b0;
      wait_cyc(4);
      prog_mode_pin <= 1'b1;
      wait_cyc(4);
   endtask : enter

   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] v);
      @(posedge clk);
      {action_code_bit1, action_code_bit0} <= act;
      byte_select_pin <= bs;
      drv_r <= v;
      wait_cyc(4);
      load_pulse_pin <= 1'b1;
      wait_cyc(4);
      load_pulse_pin <= 1'b0;
      wait_cyc(4);
      {action_code_bit1, action_code_bit0} <= 2'h3;
      drv_r <= ~v;
   endtask : load

   task automatic strobe(input logic bs, input int low, output logic busy);
      busy = 1'b0;
      @(posedge clk);
      byte_select_pin <= bs;
      wait_cyc(2);
      write_n_pin <= 1'b0;
      repeat (low) begin
         @(posedge clk);
         #1;
         busy = busy | (ready_busy_out !== 1'b1);
      end
      @(posedge clk);
      write_n_pin <= 1'b1;
      // Waits out the busy phase before the next strobe
      repeat (30) begin
         @(posedge clk);
         #1;
         busy = busy | (ready_busy_out !== 1'b1);
      end
   endtask : strobe

   task automatic rd(input logic bs, output logic [9:0] val);
      @(posedge clk);
      #1;
      val[9] = data_oe;
      @(posedge clk);
      byte_select_pin  <= bs;
      out_enable_n_pin <= 1'b0;
      drv_r            <= ~drv_r;
      wait_cyc(5);
      #1;
      val[8:0] = {data_oe, data_in};
      @(posedge clk);
      out_enable_n_pin <= 1'b1;
      wait_cyc(4);
   endtask : rd
endmodule : prog_model
`default_nettype wire

//--- verification/parallel_program_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_program_port_tb;
   localparam int unsigned WC   = 4;
   localparam logic [7:0]  SIG0 = 8'h6e; // Arbitrary value
   localparam logic [7:0]  SIG1 = 8'h17; // Arbitrary value
   localparam logic [7:0]  SIG2 = 8'hc4; // Arbitrary value

   logic       clk;
   logic       rst;
   logic       ce;
   logic       prog_mode_pin;
   logic       load_pulse_pin;
   logic       action_code_bit0;
   logic       action_code_bit1;
   logic       byte_select_pin;
   logic       write_n_pin;
   logic       out_enable_n_pin;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic       data_oe;
   logic       ready_busy_out;
   logic [7:0] sig [3];
   int         fails;
   int         num_checks;

   always #25 clk = ~clk;

   parallel_program_port #(.WRITE_CYCLES(WC), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) u_dut (
      .clk, .rst, .ce, .prog_mode_pin, .load_pulse_pin, .action_code_bit0, .action_code_bit1,
      .byte_select_pin, .write_n_pin, .out_enable_n_pin, .data_in, .data_out, .data_oe, .ready_busy_out);

   prog_model u_prog (
      .clk, .data_out, .data_oe, .ready_busy_out, .prog_mode_pin, .load_pulse_pin, .action_code_bit0,
      .action_code_bit1, .byte_select_pin, .write_n_pin, .out_enable_n_pin, .data_in);

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] c);
      u_prog.load(2'h2, 1'b0, c);
   endtask : cmd

   task automatic rdc(input logic bs, input logic [7:0] exp, input string what);
      logic [9:0] r;
      u_prog.rd(bs, r);
      chk(r, {2'b01, exp}, what);
   endtask : rdc

   task automatic wr(input logic bs, input int low, input logic exp, input string what);
      logic b;
      u_prog.strobe(bs, low, b);
      chk({9'h000, b}, {9'h000, exp}, what);
   endtask : wr

   initial begin
      clk        = 1'b0;
      rst        = 1'b1;
      ce         = 1'b1;
      fails      = 0;
      num_checks = 0;
      sig        = '{SIG0, SIG1, SIG2};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk({8'h00, data_oe, ready_busy_out}, 10'h001, "idle after reset");
      u_prog.enter();
      $display("reset test done");

      cmd(8'h80);
      wr(1'b0, 4300, 1'b0, "erase busy");
      cmd(8'h02);
      u_prog.load(2'h0, 1'b1, 8'h0f);
      u_prog.load(2'h0, 1'b0, 8'hff);
      rdc(1'b0, 8'hff, "erased low");
      rdc(1'b1, 8'hff, "erased high");
      cmd(8'h03);
      rdc(1'b0, 8'hff, "erased data");
      $display("erase test done");

      cmd(8'h08);
      for (int i = 0; i < 3; i++) begin
         u_prog.load(2'h0, 1'b0, 8'(i));
         rdc(1'b0, sig[i], "signature");
      end
      $display("signature test done");

      cmd(8'h10);
      u_prog.load(2'h0, 1'b0, 8'h5a);
      u_prog.load(2'h1, 1'b0, 8'h12);
      u_prog.load(2'h1, 1'b1, 8'h34);
      wr(1'b0, 4, 1'b1, "low busy");
      wr(1'b1, 4, 1'b1, "high busy");
      u_prog.load(2'h0, 1'b0, 8'h5b);
      u_prog.load(2'h1, 1'b0, 8'h56);
      wr(1'b0, 4, 1'b1, "reuse command");
      cmd(8'h02);
      u_prog.load(2'h0, 1'b0, 8'h5a);
      u_prog.load(2'h3, 1'b1, 8'h00);
      rdc(1'b0, 8'h12, "word low");
      rdc(1'b1, 8'h34, "word high");
      u_prog.load(2'h0, 1'b0, 8'h5b);
      rdc(1'b0, 8'h56, "second word");
      rdc(1'b1, 8'hff, "second high");
      $display("program test done");

      cmd(8'h11);
      u_prog.load(2'h0, 1'b1, 8'h01);
      u_prog.load(2'h0, 1'b0, 8'h33);
      u_prog.load(2'h1, 1'b0, 8'h9c);
      wr(1'b0, 4, 1'b1, "data busy");
      cmd(8'h03);
      rdc(1'b0, 8'h9c, "data read");
      u_prog.load(2'h0, 1'b1, 8'h00);
      rdc(1'b0, 8'hff, "other page");
      $display("data test done");

      cmd(8'h04);
      rdc(1'b1, 8'hdf, "fuse reset");
      cmd(8'h40);
      u_prog.load(2'h1, 1'b0, 8'hfe);
      wr(1'b0, 30, 1'b0, "fuse busy");
      cmd(8'h04);
      rdc(1'b1, 8'hfe, "fuse write");
      cmd(8'h20);
      u_prog.load(2'h1, 1'b0, 8'hfd);
      wr(1'b0, 4, 1'b1, "lock busy");
      u_prog.load(2'h1, 1'b0, 8'hff);
      wr(1'b0, 4, 1'b1, "lock rewrite");
      u_prog.load(2'h1, 1'b0, 8'hfb);
      wr(1'b0, 4, 1'b1, "lock two");
      cmd(8'h04);
      rdc(1'b1, 8'h3e, "locks set");
      cmd(8'h02);
      u_prog.load(2'h0, 1'b1, 8'h0f);
      u_prog.load(2'h0, 1'b0, 8'h5a);
      rdc(1'b0, 8'hff, "locked read");
      cmd(8'h80);
      wr(1'b0, 4300, 1'b0, "erase busy");
      cmd(8'h04);
      rdc(1'b1, 8'hfe, "locks cleared");
      cmd(8'h02);
      rdc(1'b0, 8'hff, "erase after lock");
      $display("lock test done");
      complete_run();
   end

   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : parallel_program_port_tb
`default_nettype wire
